// ==== logic/opct_cfg.svh ====
/*
 Register offsets, field positions, reset values and timing counts of the
 four-bit output port with clock and tone outputs.
 Assumes inclusion by the port module and its checker only.
*/
`ifndef OPCT_CFG_SVH
`define OPCT_CFG_SVH
`define OPCT_ADDR_W 8
`define OPCT_OFF_OUT_DATA 8'h00F1
`define OPCT_OFF_RATE_CTRL 8'h00F7
`define OPCT_OUT_DATA_RESET 4'h0
`define OPCT_RATE_CTRL_RESET 4'h0
`define OPCT_RATE_SEL_LSB 0
`define OPCT_RATE_SEL_MSB 1
`define OPCT_RATE_UNUSED_BIT 2
`define OPCT_TONE_SEL_BIT 3
`define OPCT_RATE_CTRL_WMASK 4'hB
`define OPCT_SET1_TOP_DIV_LOG2 7
`define OPCT_TONE_HI_DIV_LOG2 3
`define OPCT_TONE_LO_DIV_LOG2 4
`define OPCT_OSC_PRESCALE 8
`endif

// ==== logic/opct_pkg.sv ====
/*
 Types shared by the output port: special-function choice and bus carriers.
 Assumes the constants header is compiled alongside.
*/
package opct_pkg;
  typedef enum logic [1:0] {
    OPCT_FN_PLAIN,
    OPCT_FN_CLOCK,
    OPCT_FN_TONE
  } opct_fn_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } opct_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
    logic readdatavalid;
  } opct_rsp_t;

  typedef struct packed {
    logic [3:0] out_data;
    logic [1:0] clock_rate_sel;
    logic tone_rate_sel;
    logic [6:0] osc_div;
    logic [2:0] osc_pre;
    logic answered;
    logic [31:0] readdata;
    logic [3:0] pin;
  } opct_state_t;
endpackage

// ==== logic/opct_port.sv ====
/*
 Four-bit general output port with optional divided clock output on bit 0
 and complementary tone pair on bits 1/0, reached over Avalon-MM.
 Assumes the system clock clk and an oscillator reference derived inside by
 a prescaler (one osc tick every OSC_PRESCALE clk cycles); pins are logic.
*/
`timescale 1ns/1ps
`include "opct_cfg.svh"

// Notes on behaviour
// - Four output bits, each with its own pin and writable data bit.
// - Plain mode: pin follows its stored data bit unchanged.
// - Data bits sit at 0F1H, D0..D3, writable and readable.
// - Reset clears all data bits; pins low, special outputs off.
// - Build option makes bit 0 (clock) or bits 0 and 1 (tone) special; bits 2, 3 stay plain.
// - Clock mode: bit 0 at 1 outputs clock, at 0 holds low.
// - Rate select 0F7H D1:D0 chooses choice 1..4, resets to 00.
// - Set 1..5 fixes divisors; set 1 is 128..16, each set halves.
// - Tone mode: bit 1 carries tone, bit 0 its inverse, each gated.
// - Tone data bit 1 enables waveform, 0 holds pin low.
// - Tone rate bit 0F7H D3: 1 gives 2 kHz, 0 gives 4 kHz.
// - Bit D2 of 0F7H ignores writes and reads zero.
module opct_port #(
  parameter opct_pkg::opct_fn_t SPECIAL_FN = opct_pkg::OPCT_FN_PLAIN,
  parameter int RATE_SET = 1,
  parameter int OSC_PRESCALE = `OPCT_OSC_PRESCALE
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire opct_pkg::opct_req_t avs_req,
  output opct_pkg::opct_rsp_t avs_rsp,
  output logic [3:0] out_pin
);

  // ==========================================================
  // Elaboration checks
  if (RATE_SET < 1 || RATE_SET > 5) begin : g_bad_set
    $error("RATE_SET must be 1 to 5");
  end
  if (OSC_PRESCALE < 1 || OSC_PRESCALE > 8) begin : g_bad_pre
    $error("OSC_PRESCALE must be 1 to 8");
  end

  localparam logic [2:0] PRE_TOP = 3'(OSC_PRESCALE - 1);
  localparam int SET_SHIFT = RATE_SET - 1;

  // ==========================================================
  // Decoding
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // Tap of the oscillator divider giving osc/2^k; k = 0 is the osc tick level
  function automatic logic div_tap(input logic [6:0] div, input logic osc_lvl, input int k);
    div_tap = (k == 0) ? osc_lvl : div[k - 1];
  endfunction

  opct_pkg::opct_state_t state;
  opct_pkg::opct_state_t next_state;
  logic osc_lvl;
  logic rd_hit_data;
  logic rd_hit_rate;
  logic clock_wave;
  logic tone_wave;
  int clk_k;

  assign osc_lvl = (state.osc_pre < 3'((OSC_PRESCALE + 1) / 2));
  assign rd_hit_data = hit(avs_req.address, `OPCT_OFF_OUT_DATA);
  assign rd_hit_rate = hit(avs_req.address, `OPCT_OFF_RATE_CTRL);

  // ==========================================================
  // Waveforms
  always_comb begin
    clk_k = `OPCT_SET1_TOP_DIV_LOG2 - SET_SHIFT - int'(state.clock_rate_sel);
    clock_wave = div_tap(state.osc_div, osc_lvl, clk_k);
    tone_wave = state.tone_rate_sel ? state.osc_div[`OPCT_TONE_LO_DIV_LOG2 - 1]
                                    : state.osc_div[`OPCT_TONE_HI_DIV_LOG2 - 1];
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_state = state;
    // Prescaler stands in for the oscillator; the divider steps on each osc period
    if (state.osc_pre == PRE_TOP) begin
      next_state.osc_pre = 3'h0;
      next_state.osc_div = 7'(state.osc_div + 7'h01);
    end else begin
      next_state.osc_pre = 3'(state.osc_pre + 3'h1);
    end

    // One wait cycle per access: request held, answer on second edge
    next_state.answered = (avs_req.read || avs_req.write) && !state.answered;
    if ((avs_req.read || avs_req.write) && !state.answered) begin
      next_state.readdata = 32'h0000_0000;
      if (avs_req.write && avs_req.byteenable[0]) begin
        if (rd_hit_data) begin
          next_state.out_data = avs_req.writedata[3:0];
        end
        if (rd_hit_rate) begin
          next_state.clock_rate_sel = avs_req.writedata[`OPCT_RATE_SEL_MSB:`OPCT_RATE_SEL_LSB];
          next_state.tone_rate_sel = avs_req.writedata[`OPCT_TONE_SEL_BIT];
        end
      end
      if (avs_req.read) begin
        if (rd_hit_data) begin
          next_state.readdata[3:0] = state.out_data;
        end
        if (rd_hit_rate) begin
          next_state.readdata[`OPCT_TONE_SEL_BIT] = state.tone_rate_sel;
          next_state.readdata[`OPCT_RATE_UNUSED_BIT] = 1'b0;
          next_state.readdata[`OPCT_RATE_SEL_MSB:`OPCT_RATE_SEL_LSB] = state.clock_rate_sel;
        end
      end
    end

    // Pins registered so both tone pins switch on the same edge, glitch free
    next_state.pin[3:2] = state.out_data[3:2];
    case (SPECIAL_FN)
      opct_pkg::OPCT_FN_CLOCK: begin
        next_state.pin[0] = state.out_data[0] & clock_wave;
        next_state.pin[1] = state.out_data[1];
      end
      opct_pkg::OPCT_FN_TONE: begin
        next_state.pin[1] = state.out_data[1] & tone_wave;
        next_state.pin[0] = state.out_data[0] & ~tone_wave;
      end
      default: begin
        next_state.pin[1:0] = state.out_data[1:0];
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state.out_data <= `OPCT_OUT_DATA_RESET;
      state.clock_rate_sel <= 2'h0;
      state.tone_rate_sel <= 1'b0;
      state.osc_div <= 7'h00;
      state.osc_pre <= 3'h0;
      state.answered <= 1'b0;
      state.readdata <= 32'h0000_0000;
      state.pin <= 4'h0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_rsp.waitrequest = (avs_req.read || avs_req.write) && !state.answered;
  assign avs_rsp.readdatavalid = state.answered;
  assign avs_rsp.readdata = state.readdata;
  assign out_pin = state.pin;

endmodule

// ==== verif/opct_load.sv ====
/* Load model on the port pins: counts level changes on pins 0 and 1.
 Assumes the bench pulses clear before each counting window. */
`timescale 1ns/1ps
module opct_load (
  input wire logic clk,
  input wire logic clear,
  input wire logic [3:0] out_pin,
  output int e0,
  output int e1
);
  logic [1:0] last;
  // Pure observer: pins are push-pull outputs, so the load drives nothing back
  always @(posedge clk) begin
    last <= out_pin[1:0];
    e0 <= clear ? 0 : e0 + int'(out_pin[0] != last[0]);
    e1 <= clear ? 0 : e1 + int'(out_pin[1] != last[1]);
  end
endmodule

// ==== verif/opct_port_sva.sv ====
/* Checker of the output port bus answers and pins.
 Assumes a bind onto opct_port from the bench top file. */
`timescale 1ns/1ps
`include "opct_cfg.svh"
module opct_port_sva #(parameter opct_pkg::opct_fn_t SPECIAL_FN = opct_pkg::OPCT_FN_PLAIN) (
  input wire logic clk,
  input wire logic reset_n,
  input wire opct_pkg::opct_req_t avs_req,
  input wire opct_pkg::opct_rsp_t avs_rsp,
  input wire logic [3:0] out_pin
);
  // ==========================================
  // Bus and pin relations
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire rq = avs_req.read || avs_req.write;
  wire rd = avs_req.read && !avs_rsp.waitrequest;
  wire w1 = avs_req.write && avs_req.address == `OPCT_OFF_OUT_DATA;
  wire [7:0] ad = avs_req.address;
  sequence s_open; $rose(rq); endsequence
  sequence s_held; rq && avs_rsp.waitrequest; endsequence
  property p_wait_first; s_open |-> avs_rsp.waitrequest; endproperty
  property p_wait_drop; s_held |=> !avs_rsp.waitrequest; endproperty
  property p_rd_rate; rd && ad == `OPCT_OFF_RATE_CTRL |-> avs_rsp.readdata[31:4] == 0 && !avs_rsp.readdata[2];
  endproperty
  property p_rd_data; rd && ad == `OPCT_OFF_OUT_DATA |-> avs_rsp.readdata[31:4] == 0; endproperty
  property p_rd_unmapped; rd && ad != `OPCT_OFF_OUT_DATA && ad != `OPCT_OFF_RATE_CTRL |-> avs_rsp.readdata == 0;
  endproperty
  property p_reset_pins; $rose(reset_n) |-> out_pin == 4'h0; endproperty
  // Upper pins never take a special function, so only a data write moves them
  property p_plain_hi; $changed(out_pin[3:2]) |-> $past(w1) || $past(w1, 2) || $past(w1, 3); endproperty
  property p_tone_pair; SPECIAL_FN != opct_pkg::OPCT_FN_TONE || !(out_pin[1] && out_pin[0]); endproperty
  a_wait_first: assert property (p_wait_first) else $error("waitrequest low on new request");
  a_wait_drop: assert property (p_wait_drop) else $error("waitrequest stuck high");
  a_rd_rate: assert property (p_rd_rate) else $error("rate control unused bits nonzero");
  a_rd_data: assert property (p_rd_data) else $error("data read upper bits nonzero");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");
  a_reset_pins: assert property (p_reset_pins) else $error("pins not low after reset");
  a_plain_hi: assert property (p_plain_hi) else $error("upper pins moved without write");
  a_tone_pair: assert property (p_tone_pair) else $error("tone pair not complementary");
endmodule

// ==== verif/opct_port_bench.sv ====
/* Self-checking bench of the output port in tone mode and, on a second instance, clock mode.
 Assumes the load model and checker are compiled before it. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module opct_port_bench;
  logic clk = 0;
  logic reset_n = 0;
  logic clear = 1;
  opct_pkg::opct_req_t req = '0;
  opct_pkg::opct_rsp_t rsp;
  logic [3:0] pins;
  logic [31:0] q;
  int e0, e1;
  // Second port built for clock output shares the bus, so both see every write
  opct_pkg::opct_rsp_t rsp2;
  logic [3:0] pins2;
  int e2, e3;
  int bad_count = 0;
  int cmp_count = 0;
  logic [15:0] rows [0:7] = '{16'hF1FF, 16'hF155, 16'hF7FB, 16'hF740, 16'hF788, 16'hF733, 16'h10F0, 16'hF100};
  always #4 clk = ~clk;
  // Short prescale keeps tone periods to a few dozen cycles
  opct_port #(.SPECIAL_FN(opct_pkg::OPCT_FN_TONE), .OSC_PRESCALE(2)) dut (.clk(clk), .reset_n(reset_n),
    .avs_req(req), .avs_rsp(rsp), .out_pin(pins));
  opct_load ld (.clk(clk), .clear(clear), .out_pin(pins), .e0(e0), .e1(e1));
  // Set 5 with a prescale of 2: choice 4 toggles every cycle, choice 1 every 8 cycles
  opct_port #(.SPECIAL_FN(opct_pkg::OPCT_FN_CLOCK), .RATE_SET(5), .OSC_PRESCALE(2)) dut_clk (.clk(clk),
    .reset_n(reset_n), .avs_req(req), .avs_rsp(rsp2), .out_pin(pins2));
  opct_load ld2 (.clk(clk), .clear(clear), .out_pin(pins2), .e0(e2), .e1(e3));
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] d, input logic [3:0] be);
    int n;
    n = 0;
    req.address <= a; req.read <= !w; req.write <= w; req.writedata <= {28'h000_0000, d}; req.byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 20);
    // A slave that never answers counts against the run
    if (rsp.waitrequest !== 1'b0) bad_count++;
    q = rsp.readdata;
    req.read <= 1'b0; req.write <= 1'b0;
    @(posedge clk);
  endtask
  // Tone window: 64 cycles, osc/8 gives 8 edges, osc/16 gives 4, one either way for phase
  task automatic tone(input logic [3:0] d, input int l0, input int h0, input int l1, input int h1,
    input int l2, input int h2);
    acc(1, 8'hF1, d, 4'hF);
    clear <= 1'b1; @(posedge clk); clear <= 1'b0;
    repeat (64) @(posedge clk);
    `CHK("edges0", 1'b1, (e0 >= l0 && e0 <= h0))
    `CHK("edges1", 1'b1, (e1 >= l1 && e1 <= h1))
    `CHK("edges_clk", 1'b1, (e2 >= l2 && e2 <= h2))
    `CHK("clk_pin", d[0] ? pins2[0] : 1'b0, pins2[0])
  endtask
  task tally_and_finish;
    $display("checks %0d bad %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #50000; bad_count++; tally_and_finish;
  end
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      acc(1, rows[i][15:8], rows[i][7:4], 4'hF);
      acc(0, rows[i][15:8], 4'h0, 4'hF);
      `CHK("readback", {28'h000_0000, rows[i][3:0]}, q)
    end
    tone(4'hF, 7, 9, 7, 9, 63, 65);
    `CHK("upper", 2'b11, pins[3:2])
    `CHK("plain1", 1'b1, pins2[1])
    tone(4'h2, 0, 0, 7, 9, 0, 0);
    tone(4'h0, 0, 0, 0, 0, 0, 0);
    acc(1, 8'hF7, 4'h8, 4'hF);
    tone(4'h3, 3, 5, 3, 5, 7, 9);
    acc(1, 8'hF1, 4'hC, 4'h0);
    acc(0, 8'hF1, 4'h0, 4'hF);
    `CHK("be_off", 32'h0000_0003, q)
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    `CHK("rst_pins", 4'h0, pins)
    acc(0, 8'hF7, 4'h0, 4'hF);
    `CHK("rst_rate", 32'h0000_0000, q)
    tally_and_finish;
  end
endmodule
bind opct_port opct_port_sva #(.SPECIAL_FN(SPECIAL_FN)) chk (.clk(clk), .reset_n(reset_n), .avs_req(avs_req),
  .avs_rsp(avs_rsp), .out_pin(out_pin));
